// ===== logic/printer_parallel_input_port.sv
// Receive side of the printer's parallel input port with an APB status view
`timescale 1ns/1ps
module printer_parallel_input_port #(
    parameter int BUSY_CYCLES  = pport_pkg::BUSY_HOLD_CYCLES,
    parameter int INIT_CYCLES  = pport_pkg::INIT_MIN_CYCLES,
    parameter int FEED_CYCLES  = pport_pkg::FEED_CYCLES
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    // Host side of the port
    input  wire logic [7:0]  DATA,
    input  wire logic        DATA_STROBE_N,
    input  wire logic        HOST_INIT_REQUEST_N,
    output logic             CHAR_ACCEPT_PULSE_N,
    output logic             BUSY,
    output logic             PAPER_OUT,
    output logic             ONLINE,
    output logic             ERROR_N,
    // Panel, sensor and board switches
    input  wire logic        ONLINE_SWITCH,
    input  wire logic        PAPER_EMPTY,
    input  wire logic        SELFTEST_OPTION_SWITCH,
    // Received characters to the print engine
    output logic             CHAR_VALID,
    output logic [7:0]       CHAR_CODE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    typedef enum logic [2:0] {
        S_IDLE, S_HOLD, S_ACK, S_SELFTEST, S_SELFTEST_WAIT
    } port_state_e;

    logic        rst_sync_a;
    logic        rst_sync_b;
    logic        strobe_q;
    logic [15:0] init_count;
    logic        init_reset;
    logic        por_done;
    port_state_e state;
    port_state_e next_state;
    logic [7:0]  rx_code;
    logic [7:0]  st_code;
    logic [6:0]  st_left;
    logic [31:0] control;
    logic [31:0] char_count;
    logic        timer_load;
    logic [23:0] timer_value;
    logic        timer_done;
    logic        emit;
    logic [7:0]  emit_code;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    wire rst_n = rst_sync_b;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            init_count <= '0;
        end else if (HOST_INIT_REQUEST_N) begin
            init_count <= '0;
        end else if (init_count != INIT_CYCLES[15:0]) begin
            init_count <= init_count + 16'h0001;
        end
    end

    assign init_reset = (init_count == INIT_CYCLES[15:0]);

    wire strobe_fall  = strobe_q && !DATA_STROBE_N;
    wire online_now   = ONLINE_SWITCH && !control[pport_pkg::CT_HOLD_OFF];
    wire st_is_feed   = (st_code == pport_pkg::CODE_CR) || (st_code == pport_pkg::CODE_LF);
    wire [23:0] st_len   = st_is_feed ? FEED_CYCLES[23:0] : BUSY_CYCLES[23:0];
    wire [23:0] ack_len  = pport_pkg::ACK_CYCLES[23:0];

    // Next state of the port sequencer
    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = '0;
        case (state)
            S_IDLE: begin
                if (!por_done && SELFTEST_OPTION_SWITCH) begin
                    next_state  = S_SELFTEST;
                end else if (strobe_fall && online_now) begin
                    next_state  = S_HOLD;
                end
            end
            S_HOLD: begin
                if (timer_done) begin
                    next_state  = S_ACK;
                    timer_load  = 1'b1;
                    timer_value = ack_len;
                end
            end
            S_ACK: begin
                if (timer_done) begin
                    next_state = S_IDLE;
                end
            end
            S_SELFTEST: begin
                next_state  = S_SELFTEST_WAIT;
                timer_load  = 1'b1;
                timer_value = st_len;
            end
            S_SELFTEST_WAIT: begin
                if (timer_done) begin
                    next_state = (st_left == 7'h00) ? S_IDLE : S_SELFTEST;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (state == S_IDLE && next_state == S_HOLD) begin
            timer_load  = 1'b1;
            timer_value = ((DATA == pport_pkg::CODE_CR) || (DATA == pport_pkg::CODE_LF))
                          ? FEED_CYCLES[23:0] : BUSY_CYCLES[23:0];
        end
    end

    pport_timer #(
        .WIDTH (24)
    ) u_timer (
        .clk     (CLOCK),
        .rst_n   (rst_n),
        .load    (timer_load),
        .value   (timer_value),
        .expired (timer_done)
    );

    wire sync_clear = init_reset;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state    <= S_IDLE;
            strobe_q <= 1'b1;
            por_done <= 1'b0;
            rx_code  <= 8'h00;
            st_code  <= 8'h00;
            st_left  <= 7'h00;
        end else if (sync_clear) begin
            state    <= S_IDLE;
            strobe_q <= DATA_STROBE_N;
            por_done <= 1'b1;
        end else begin
            state    <= next_state;
            strobe_q <= DATA_STROBE_N;
            if (state == S_IDLE) begin
                por_done <= 1'b1;
            end
            if (state == S_IDLE && next_state == S_HOLD) begin
                rx_code <= DATA;
            end
            if (state == S_IDLE && next_state == S_SELFTEST) begin
                st_code <= pport_pkg::SELFTEST_FIRST;
                st_left <= 7'(pport_pkg::SELFTEST_CHARS - 1);
            end else if (state == S_SELFTEST_WAIT && timer_done && st_left != 7'h00) begin
                st_code <= st_code + 8'h01;
                st_left <= st_left - 7'h01;
            end
        end
    end

    assign emit      = (state == S_IDLE && next_state == S_HOLD) || (state == S_SELFTEST);
    assign emit_code = (state == S_SELFTEST) ? st_code : DATA;

    // Host-facing status outputs and the engine character outputs, all registered
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            BUSY                <= 1'b1;
            CHAR_ACCEPT_PULSE_N <= 1'b1;
            PAPER_OUT           <= 1'b1;
            ONLINE              <= 1'b0;
            ERROR_N             <= 1'b1;
            CHAR_VALID          <= 1'b0;
            CHAR_CODE           <= 8'h00;
        end else begin
            // Busy when not idle or when offline or held off, also through init and the self-test start
            BUSY                <= (next_state != S_IDLE) || !online_now || sync_clear
                                   || (!por_done && SELFTEST_OPTION_SWITCH);
            CHAR_ACCEPT_PULSE_N <= !(next_state == S_ACK) || sync_clear;
            PAPER_OUT           <= PAPER_EMPTY || !ONLINE_SWITCH;
            ONLINE              <= ONLINE_SWITCH;
            ERROR_N             <= !PAPER_EMPTY;
            CHAR_VALID          <= emit && !sync_clear;
            if (emit) begin
                CHAR_CODE <= emit_code;
            end
        end
    end

    // APB decode, zero wait states
    wire        apb_access = PSEL && PENABLE;
    wire        hit_rx     = (PADDR == pport_pkg::APB_RX_DATA);
    wire        hit_status = (PADDR == pport_pkg::APB_STATUS);
    wire        hit_ctrl   = (PADDR == pport_pkg::APB_CONTROL);
    wire        hit_count  = (PADDR == pport_pkg::APB_COUNT);
    wire        mapped     = hit_rx || hit_status || hit_ctrl || hit_count;
    wire        bad        = !mapped || (PWRITE && !hit_ctrl);
    wire [31:0] status_word = {27'h0, (state == S_IDLE) && por_done,
                               (state == S_SELFTEST) || (state == S_SELFTEST_WAIT),
                               PAPER_OUT, ONLINE, BUSY};
    wire [31:0] read_mux = hit_rx     ? {24'h0, rx_code} :
                           hit_status ? status_word :
                           hit_ctrl   ? control :
                           hit_count  ? char_count : 32'h0;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            control    <= pport_pkg::CONTROL_RESET;
            char_count <= 32'h0;
            PRDATA     <= 32'h0;
            PREADY     <= 1'b0;
            PSLVERR    <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && bad;
            if (PSEL && !PENABLE && !PWRITE) begin
                PRDATA <= read_mux;
            end
            if (apb_access && PREADY && PWRITE && hit_ctrl) begin
                control <= {31'h0, PWDATA[pport_pkg::CT_HOLD_OFF]};
            end
            if (CHAR_VALID) begin
                char_count <= char_count + 32'h1;
            end
        end
    end
endmodule

// ===== logic/pport_pkg.sv
// Constants and carrier types for the parallel input port
package pport_pkg;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int BUSY_HOLD_TIME_US = 400;
    localparam int BUSY_HOLD_CYCLES = (BUSY_HOLD_TIME_US * (CLOCK_HZ / 1_000_000));
    localparam int INIT_MIN_TIME_US = 500;
    localparam int INIT_MIN_CYCLES = (INIT_MIN_TIME_US * (CLOCK_HZ / 1_000_000)) + 1;
    localparam int ACK_TIME_US = 5;
    localparam int ACK_CYCLES = ACK_TIME_US * (CLOCK_HZ / 1_000_000);
    localparam int FEED_TIME_US = 100_000;
    localparam int FEED_CYCLES = FEED_TIME_US * (CLOCK_HZ / 1_000_000);
    localparam int SELFTEST_CHARS = 96;
    localparam logic [7:0] CODE_LF = 8'h0a;
    localparam logic [7:0] CODE_CR = 8'h0d;
    localparam logic [7:0] SELFTEST_FIRST = 8'h20;
    localparam logic [31:0] APB_RX_DATA = 32'h0000_0000;
    localparam logic [31:0] APB_STATUS = 32'h0000_0004;
    localparam logic [31:0] APB_CONTROL = 32'h0000_0008;
    localparam logic [31:0] APB_COUNT = 32'h0000_000c;
    localparam int ST_BUSY = 0;
    localparam int ST_ONLINE = 1;
    localparam int ST_PAPER_OUT = 2;
    localparam int ST_SELFTEST = 3;
    localparam int ST_DONE = 4;
    localparam int CT_HOLD_OFF = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    typedef struct packed {
        logic       busy;
        logic       ack_n;
        logic       paper_out;
        logic       online;
        logic       error_n;
    } host_status_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } char_s;
endpackage

// ===== logic/pport_timer.sv
// Loadable down-counter used for the port's timed intervals
`timescale 1ns/1ps
module pport_timer #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    // Status
    output logic                  expired
);
    logic [WIDTH-1:0] count;
    wire              running = (count != '0);

    assign expired = !running;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= value;
        end else if (running) begin
            count <= count - 1'b1;
        end
    end
endmodule

// ===== test/pport_checker_assertions.sv
// Port-level assertions for the parallel input port
`timescale 1ns/1ps
module pport_checker #(
    parameter int BUSY_CYCLES = 20,
    parameter int FEED_CYCLES = 100
) (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       ARST_N,
    // Host side
    input wire logic [7:0] DATA,
    input wire logic       DATA_STROBE_N,
    input wire logic       CHAR_ACCEPT_PULSE_N,
    input wire logic       BUSY,
    input wire logic       PAPER_OUT,
    input wire logic       ONLINE,
    input wire logic       ERROR_N,
    // Switches and engine side
    input wire logic       ONLINE_SWITCH,
    input wire logic       PAPER_EMPTY,
    input wire logic       CHAR_VALID,
    input wire logic [7:0] CHAR_CODE
);
    logic [2:0] rcnt;
    int         blen;
    logic       feed;
    // Outputs settle a few edges after reset release
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rcnt <= 3'h0;
            blen <= 0;
            feed <= 1'b0;
        end else begin
            rcnt <= (rcnt == 3'h7) ? rcnt : rcnt + 3'h1;
            blen <= CHAR_VALID ? 0 : blen + 1;
            feed <= CHAR_VALID ? (CHAR_CODE == 8'h0d || CHAR_CODE == 8'h0a) : feed;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N || rcnt < 3'h5);
    a_online_copy: assert property (ONLINE == $past(ONLINE_SWITCH))
        else $error("online indicator does not follow switch");
    a_paper_out_map: assert property (PAPER_OUT == $past(PAPER_EMPTY || !ONLINE_SWITCH))
        else $error("paper out indication wrong");
    a_error_flag: assert property (ERROR_N == !$past(PAPER_EMPTY))
        else $error("error output wrong");
    a_capture_byte: assert property ($fell(DATA_STROBE_N) && !BUSY
        |=> CHAR_VALID && CHAR_CODE == $past(DATA)) else $error("byte not captured");
    a_valid_busy: assert property (CHAR_VALID |-> BUSY ##1 !CHAR_VALID)
        else $error("char valid without busy");
    a_ack_busy: assert property (!CHAR_ACCEPT_PULSE_N |-> BUSY)
        else $error("busy dropped during char_accept_pulse");
    a_busy_release: assert property ($rose(CHAR_ACCEPT_PULSE_N) |-> !BUSY)
        else $error("busy not released at char_accept_pulse end");
    a_busy_length: assert property ($fell(CHAR_ACCEPT_PULSE_N)
        |-> blen >= (feed ? FEED_CYCLES : BUSY_CYCLES) - 1) else $error("busy too short");
    cover property ($fell(CHAR_ACCEPT_PULSE_N));
    cover property (CHAR_VALID && CHAR_CODE == 8'h0d);
    cover property (PAPER_OUT && ONLINE);
endmodule

bind printer_parallel_input_port pport_checker #(
    .BUSY_CYCLES(BUSY_CYCLES), .FEED_CYCLES(FEED_CYCLES)
) u_chk (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .DATA(DATA), .DATA_STROBE_N(DATA_STROBE_N),
    .CHAR_ACCEPT_PULSE_N(CHAR_ACCEPT_PULSE_N), .BUSY(BUSY), .PAPER_OUT(PAPER_OUT),
    .ONLINE(ONLINE), .ERROR_N(ERROR_N), .ONLINE_SWITCH(ONLINE_SWITCH),
    .PAPER_EMPTY(PAPER_EMPTY), .CHAR_VALID(CHAR_VALID), .CHAR_CODE(CHAR_CODE)
);

// ===== test/pport_host.sv
// Host computer model driving the parallel port
`timescale 1ns/1ps
module pport_host (
    // Clock and printer answer
    input  wire logic CLOCK,
    input  wire logic BUSY,
    // Host drive
    output logic [7:0] DATA,
    output logic       DATA_STROBE_N,
    output logic       HOST_INIT_REQUEST_N
);
    initial begin
        DATA = 8'h00;
        DATA_STROBE_N = 1'b1;
        HOST_INIT_REQUEST_N = 1'b1;
    end
    // waits for busy low unless told to break the rule
    task automatic send(input logic [7:0] code, input bit brk, input int gap, output bit ok);
        int n;
        n = 0;
        while (BUSY !== 1'b0 && !brk && n < 2000) begin
            @(posedge CLOCK);
            n++;
        end
        ok = n < 2000;
        repeat (gap) @(posedge CLOCK);
        // byte set up one cycle ahead of the strobe
        DATA <= code;
        @(posedge CLOCK);
        DATA_STROBE_N <= 1'b0;
        repeat (2) @(posedge CLOCK);
        DATA_STROBE_N <= 1'b1;
        @(posedge CLOCK);
        // Lines no longer held show a changed value
        DATA <= ~code;
    endtask
    // init held low for the given width
    task automatic init_pulse(input int len);
        HOST_INIT_REQUEST_N <= 1'b0;
        repeat (len) @(posedge CLOCK);
        HOST_INIT_REQUEST_N <= 1'b1;
    endtask
endmodule

// ===== test/printer_parallel_input_port_tb_top.sv
// Self-checking bench for the printer parallel input port
`timescale 1ns/1ps
module printer_parallel_input_port_tb_top;
    localparam int INIT_C = 10;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        online_sw = 1'b1;
    logic        paper_empty = 1'b0;
    logic        selftest_sw = 1'b1;
    logic [7:0]  data, char_code, code;
    logic        strobe_n, init_n, ack_n, busy, paper_out, online, error_n, char_valid;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          compares = 0;
    bit          ok;
    always #10 clock = ~clock;
    printer_parallel_input_port #(.BUSY_CYCLES(20), .INIT_CYCLES(INIT_C), .FEED_CYCLES(100)) u_dut (
        .CLOCK(clock), .ARST_N(arst_n), .DATA(data), .DATA_STROBE_N(strobe_n),
        .HOST_INIT_REQUEST_N(init_n), .CHAR_ACCEPT_PULSE_N(ack_n), .BUSY(busy),
        .PAPER_OUT(paper_out), .ONLINE(online), .ERROR_N(error_n),
        .ONLINE_SWITCH(online_sw), .PAPER_EMPTY(paper_empty),
        .SELFTEST_OPTION_SWITCH(selftest_sw), .CHAR_VALID(char_valid), .CHAR_CODE(char_code),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    pport_host u_host (.CLOCK(clock), .BUSY(busy), .DATA(data), .DATA_STROBE_N(strobe_n),
        .HOST_INIT_REQUEST_N(init_n));
    task automatic conclude();
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_up();
        fail_count++;
        conclude();
    endtask
    task automatic drain(input int lim);
        int n;
        n = 0;
        while ((exp_q.size() != 0 || busy !== 1'b0) && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (n >= lim) give_up();
    endtask
    task automatic put(input logic [7:0] c, input bit brk);
        if (!brk) exp_q.push_back(c);
        u_host.send(c, brk, $urandom_range(3), ok);
        if (!ok) give_up();
    endtask
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 50) give_up();
    endtask
    // Oldest expected byte against each received character
    always @(posedge clock) begin
        if (char_valid === 1'b1 && exp_q.size() == 0) chk("extra char", 32'h0, 32'h1);
        else if (char_valid === 1'b1) chk("char", 32'(exp_q.pop_front()), 32'(char_code));
    end
    initial begin
        void'($urandom(93374));
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        for (int i = 0; i < 96; i++) exp_q.push_back(8'h20 + 8'(i));
        drain(60000);
        selftest_sw <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            online_sw <= i[0];
            paper_empty <= i[1];
            repeat (4) @(posedge clock);
            chk("online", 32'(i[0]), 32'(online));
            chk("paper_out", 32'(i[1] | !i[0]), 32'(paper_out));
            chk("error_n", 32'(!i[1]), 32'(error_n));
            if (!i[1]) chk("busy", 32'(!i[0]), 32'(busy));
        end
        online_sw <= 1'b1;
        paper_empty <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            code = i < 8 ? 8'h01 << i : 8'($urandom);
            code = i == 10 ? pport_pkg::CODE_CR : i == 11 ? pport_pkg::CODE_LF : code;
            put(code, 1'b0);
        end
        put(8'h55, 1'b0);
        put(8'haa, 1'b1);
        drain(3000);
        put(8'h3c, 1'b0);
        u_host.init_pulse(INIT_C + 2);
        repeat (3) @(posedge clock);
        chk("busy after init", 32'h0, 32'(busy));
        chk("ack after init", 32'h1, 32'(ack_n));
        apb(1'b0, pport_pkg::APB_STATUS, 32'h0);
        chk("status", 32'h12, rd);
        apb(1'b0, pport_pkg::APB_RX_DATA, 32'h0);
        chk("rx data", 32'h3c, rd);
        chk("rx data err", 32'h0, 32'(err));
        apb(1'b0, pport_pkg::APB_COUNT, 32'h0);
        chk("char count", 32'h6e, rd);
        apb(1'b1, pport_pkg::APB_CONTROL, 32'h1);
        repeat (3) @(posedge clock);
        chk("busy hold-off", 32'h1, 32'(busy));
        apb(1'b1, pport_pkg::APB_STATUS, 32'h5);
        chk("ro write err", 32'h1, 32'(err));
        apb(1'b0, 32'h0000_0010, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, pport_pkg::APB_CONTROL, 32'h0);
        put(8'hc3, 1'b0);
        drain(3000);
        conclude();
    end
endmodule
